// ===== dch_pkg.sv
`default_nettype none
package dch_pkg;
  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [6:0] KEY_OPEN_ALL = 7'h01;
  localparam logic [6:0] KEY_OPEN_ADDR = 7'h02;
  localparam logic [6:0] KEY_OPEN_NAME = 7'h03;
  localparam logic [6:0] KEY_CLOSE = 7'h04;
  localparam logic [6:0] KEY_BLOCK = 7'h05;
  localparam logic [6:0] KEY_ADVANCE = 7'h06;
  localparam logic [6:0] KEY_CLR_PTR = 7'h07;
  localparam logic [6:0] KEY_BUF = 7'h08;
  localparam logic [6:0] KEY_COUNT = 7'h09;
  localparam logic [6:0] KEY_NAME_WR = 7'h0a;
  localparam logic [6:0] KEY_DESTROY = 7'h0b;
  localparam logic [6:0] KEY_START = 7'h0c;
  localparam logic [6:0] KEY_RD_STATUS = 7'h10;
  localparam logic [6:0] KEY_RD_ADDR = 7'h11;
  localparam logic [6:0] KEY_RD_NAME = 7'h12;
  localparam logic [6:0] KEY_RD_PTR = 7'h13;
  localparam logic [6:0] KEY_RD_RESULT = 7'h14;
  localparam logic [6:0] KEY_RD_SCOUNT = 7'h15;
  localparam logic [6:0] KEY_RD_LIMIT = 7'h16;
  // ------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_RESULT = 8'h04;
  localparam logic [7:0] REG_SCOUNT = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam int CTRL_DONE_BIT = 0;
  localparam int ST_PRESENT_BIT = 15;
  localparam int ST_OPEN_BIT = 0;
  localparam int ST_BLOCK_BIT = 1;
  localparam int ST_REJECT_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  localparam int ST_NAMEOK_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [9:0] PTR_RESET = 10'h000;
  typedef struct packed {
    logic [6:0] key;
    logic strobe;
    logic [15:0] data;
  } dch_cmd_t;
endpackage
`default_nettype wire

// ===== dch_cell.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
// Functional notes
// RULE_01: One shared 16-bit data bus, no inter-cell path
// RULE_02: Seven key lines, each code one command
// RULE_03: Ignore keys and data without strobe
// RULE_04: Key decides operand in, value out, none
// RULE_05: Full commands only open, unblocked, unrejected
// RULE_06: Open-all key opens every cell
// RULE_07: Open-by-address compares switch with bus
// RULE_08: Open-by-name matches stored relation name
// RULE_09: Open holds until close key
// RULE_10: Block key blocks every open cell
// RULE_11: Advance rejects current, unblocks first blocked
// RULE_12: Priority chain selects one cell
// RULE_13: Status top bit reads one always
// RULE_14: Refuse commands while a pass runs; code still accepts block, advance and read keys
// RULE_15: 1K buffer, pointer clearable by key
// RULE_16: Buffer write stores then advances pointer
// RULE_17: Buffer read returns then advances pointer
// RULE_18: Controller preloads buffer and insert count
// RULE_19: Controller writes retrieval count first
// RULE_20: Status, address, name, pointer, result readable
// RULE_21: Counter of satisfied tuples, last pass
// RULE_22: Cell alone ends its pass
// RULE_23: Each key access about one microsecond
// RULE_24: Name 16-bit; destroy forces mismatch
// RULE_25: Drive bus only on selected read
// RULE_26: Reset: closed, unblocked, unrejected, idle, pointer zero
module dch_cell #(
  parameter int BUF_DEPTH = 1024,
  parameter int PTR_W = 10
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic [6:0] key_in, // Key lines pin
  input wire logic key_en_in, // Key strobe pin
  input wire logic [15:0] data_in, // Data bus input
  output logic [15:0] data_out, // Data bus output
  output logic data_oe_n, // Data bus enable, low drives
  input wire logic [7:0] cell_addr_sw, // Address switches
  input wire logic prio_in, // Priority chain in
  output logic prio_out, // Priority chain out
  output logic running, // Pass under way
  input wire logic [31:0] s_awaddr, // AXI write address
  input wire logic s_awvalid, // AXI
  output logic s_awready, // AXI
  input wire logic [31:0] s_wdata, // AXI
  input wire logic [3:0] s_wstrb, // AXI
  input wire logic s_wvalid, // AXI
  output logic s_wready, // AXI
  output logic [1:0] s_bresp, // AXI
  output logic s_bvalid, // AXI
  input wire logic s_bready, // AXI
  input wire logic [31:0] s_araddr, // AXI
  input wire logic s_arvalid, // AXI
  output logic s_arready, // AXI
  output logic [31:0] s_rdata, // AXI
  output logic [1:0] s_rresp, // AXI
  output logic s_rvalid, // AXI
  input wire logic s_rready // AXI
);
  if (BUF_DEPTH != (1 << PTR_W) || PTR_W < 1 || PTR_W > 16)
  begin : g_bad_depth
    $error("BUF_DEPTH must equal 2**PTR_W");
  end
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  dch_pkg::dch_cmd_t cmd_s1_r, cmd_s2_r;
  logic [7:0] sw_s1_r, sw_s2_r;
  logic prio_s1_r, prio_s2_r;
  logic strobe_d_r, act;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_s1_r <= '0;
      cmd_s2_r <= '0;
      sw_s1_r <= 8'h00;
      sw_s2_r <= 8'h00;
      prio_s1_r <= 1'b0;
      prio_s2_r <= 1'b0;
      strobe_d_r <= 1'b0;
    end
    else
    begin
      // RULE_01: shared data bus sampled
      cmd_s1_r <= '{key: key_in, strobe: key_en_in, data: data_in};
      cmd_s2_r <= cmd_s1_r;
      sw_s1_r <= cell_addr_sw;
      sw_s2_r <= sw_s1_r;
      prio_s1_r <= prio_in;
      prio_s2_r <= prio_s1_r;
      strobe_d_r <= cmd_s2_r.strobe;
    end
  end
  // One action per strobe, at its leading edge
  // RULE_03: strobe qualifies all
  assign act = cmd_s2_r.strobe && !strobe_d_r;
  logic [6:0] key;
  logic [15:0] din, name_r;
  // RULE_02: seven key lines
  assign key = cmd_s2_r.key;
  assign din = cmd_s2_r.data;
  // ------------------------------------------------------------
  // Selection state
  // ------------------------------------------------------------
  logic open_r, blocked_r, rejected_r, run_r, named_r;
  logic sel, free;
  // RULE_05: full set gating
  assign sel = open_r && !blocked_r && !rejected_r;
  // RULE_14: refuse while running
  assign free = sel && !run_r;
  // RULE_12: first blocked cell sees priority with no blocked before it
  logic first_blocked;
  assign first_blocked = open_r && blocked_r && prio_s2_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prio_out <= 1'b0;
    else
      prio_out <= prio_s2_r && !(open_r && blocked_r);
  end
  // RULE_26: reset closes cell
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      open_r <= 1'b0;
    else if (act && !run_r)
    begin
      // RULE_06: open all
      if (key == dch_pkg::KEY_OPEN_ALL)
        open_r <= 1'b1;
      // RULE_07: address match
      else if (key == dch_pkg::KEY_OPEN_ADDR && din[7:0] == sw_s2_r)
        open_r <= 1'b1;
      // RULE_08: name match
      else if (key == dch_pkg::KEY_OPEN_NAME && named_r && din == name_r)
        open_r <= 1'b1;
      // RULE_09: only close clears
      else if (key == dch_pkg::KEY_CLOSE)
        open_r <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blocked_r <= 1'b0;
      rejected_r <= 1'b0;
    end
    else if (act && open_r)
    begin
      // RULE_10: block open cells
      if (key == dch_pkg::KEY_BLOCK)
      begin
        blocked_r <= 1'b1;
        rejected_r <= 1'b0;
      end
      // RULE_11: advance
      else if (key == dch_pkg::KEY_ADVANCE)
      begin
        if (sel)
          rejected_r <= 1'b1;
        else if (first_blocked)
          blocked_r <= 1'b0;
      end
      else if (key == dch_pkg::KEY_CLOSE && !run_r)
      begin
        blocked_r <= 1'b0;
        rejected_r <= 1'b0;
      end
    end
  end
  // RULE_24: name register and destroy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      name_r <= 16'h0000;
      named_r <= 1'b0;
    end
    else if (act && free)
    begin
      if (key == dch_pkg::KEY_NAME_WR)
      begin
        name_r <= din;
        named_r <= 1'b1;
      end
      else if (key == dch_pkg::KEY_DESTROY)
        named_r <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Pass control, count and limit
  // ------------------------------------------------------------
  logic [15:0] limit_r, scount_r, result_r;
  logic done_pulse;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      limit_r <= 16'h0000;
    // RULE_18: insert count
    // RULE_19: retrieval count
    else if (act && free && key == dch_pkg::KEY_COUNT)
      limit_r <= din;
  end
  // RULE_22: cell ends pass
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_r <= 1'b0;
    else if (run_r && done_pulse)
      run_r <= 1'b0;
    else if (act && free && key == dch_pkg::KEY_START)
      run_r <= 1'b1;
  end
  assign running = run_r;
  // ------------------------------------------------------------
  // I/O buffer
  // ------------------------------------------------------------
  // RULE_15: buffer and pointer
  logic [15:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0] ptr_r;
  logic buf_wr, buf_rd_key;
  assign buf_wr = act && free && key == dch_pkg::KEY_BUF && !cmd_s2_r.key[6];
  assign buf_rd_key = act && sel && key == (dch_pkg::KEY_BUF | 7'h40);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_r <= PTR_W'(dch_pkg::PTR_RESET);
    else if (act && free && key == dch_pkg::KEY_CLR_PTR)
      ptr_r <= PTR_W'(dch_pkg::PTR_RESET);
    // RULE_16: write then advance
    // RULE_17: read then advance
    else if (buf_wr || buf_rd_key)
      ptr_r <= ptr_r + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (buf_wr)
      buf_mem[ptr_r] <= din;
  end
  // ------------------------------------------------------------
  // Bus drive
  // ------------------------------------------------------------
  // RULE_20: readable values
  // RULE_13: top status bit one
  logic [15:0] status;
  always_comb
  begin
    status = 16'h0000;
    status[dch_pkg::ST_PRESENT_BIT] = 1'b1;
    status[dch_pkg::ST_OPEN_BIT] = open_r;
    status[dch_pkg::ST_BLOCK_BIT] = blocked_r;
    status[dch_pkg::ST_REJECT_BIT] = rejected_r;
    status[dch_pkg::ST_RUN_BIT] = run_r;
    status[dch_pkg::ST_NAMEOK_BIT] = named_r;
  end
  // RULE_04: keys returning a value
  logic rd_hit;
  logic [15:0] rd_val;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    case (key)
      dch_pkg::KEY_RD_STATUS: rd_val = status;
      dch_pkg::KEY_RD_ADDR: rd_val = {8'h00, sw_s2_r};
      dch_pkg::KEY_RD_NAME: rd_val = name_r;
      dch_pkg::KEY_RD_PTR: rd_val = 16'(ptr_r);
      dch_pkg::KEY_RD_RESULT: rd_val = result_r;
      dch_pkg::KEY_RD_SCOUNT: rd_val = scount_r;
      dch_pkg::KEY_RD_LIMIT: rd_val = limit_r;
      7'h48: rd_val = buf_mem[ptr_r];
      default: rd_hit = 1'b0;
    endcase
  end
  // RULE_25: drive only on selected read, hold while strobe lasts
  // Status read stays live while running so collective polls work
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_oe_n <= 1'b1;
      data_out <= 16'h0000;
    end
    else if (!cmd_s2_r.strobe)
      data_oe_n <= 1'b1;
    else if (act && sel && rd_hit)
    begin
      data_oe_n <= 1'b0;
      data_out <= rd_val;
    end
  end
  // ------------------------------------------------------------
  // AXI4-Lite slave: track-side result, count and pass done
  // ------------------------------------------------------------
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  assign do_write = aw_got_r && w_got_r && !s_bvalid;
  assign done_pulse = do_write && aw_addr_r == dch_pkg::REG_CTRL &&
    w_strb_r[0] && w_data_r[dch_pkg::CTRL_DONE_BIT];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= dch_pkg::RESP_OKAY;
    end
    else
    begin
      s_awready <= !aw_got_r && !s_awready && s_awvalid;
      s_wready <= !w_got_r && !s_wready && s_wvalid;
      if (s_awvalid && s_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_awaddr[7:0];
      end
      if (s_wvalid && s_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      if (do_write)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= (aw_addr_r == dch_pkg::REG_RESULT || aw_addr_r == dch_pkg::REG_SCOUNT ||
          aw_addr_r == dch_pkg::REG_CTRL) ? dch_pkg::RESP_OKAY : dch_pkg::RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end
  // RULE_21: satisfied count of last pass
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_r <= 16'h0000;
      scount_r <= 16'h0000;
    end
    else if (do_write)
    begin
      if (aw_addr_r == dch_pkg::REG_RESULT && w_strb_r[1:0] == 2'b11)
        result_r <= w_data_r[15:0];
      if (aw_addr_r == dch_pkg::REG_SCOUNT && w_strb_r[1:0] == 2'b11)
        scount_r <= w_data_r[15:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= dch_pkg::RESP_OKAY;
    end
    else
    begin
      s_arready <= !s_arready && !s_rvalid && s_arvalid;
      if (s_arvalid && s_arready)
      begin
        s_rvalid <= 1'b1;
        s_rresp <= dch_pkg::RESP_OKAY;
        case (s_araddr[7:0])
          dch_pkg::REG_STATUS: s_rdata <= {16'h0000, status};
          dch_pkg::REG_RESULT: s_rdata <= {16'h0000, result_r};
          dch_pkg::REG_SCOUNT: s_rdata <= {16'h0000, scount_r};
          dch_pkg::REG_CTRL: s_rdata <= {16'h0000, limit_r};
          default:
          begin
            s_rdata <= 32'h0;
            s_rresp <= dch_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== dch_cell_assertions.sv
`default_nettype none
module dch_cell_checker (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [6:0] key_in, // Key
  input wire logic key_en_in, // Strobe
  input wire logic [15:0] data_out, // Drive value
  input wire logic data_oe_n, // Drive enable
  input wire logic prio_in, // Chain in
  input wire logic prio_out, // Chain out
  input wire logic running, // Pass
  input wire logic s_wvalid, // AXI
  input wire logic s_wready, // AXI
  input wire logic s_bvalid, // AXI
  input wire logic s_arvalid, // AXI
  input wire logic s_arready, // AXI
  input wire logic s_rvalid // AXI
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_idle_bus_free: assert property (!key_en_in [*6] |=> data_oe_n)
    else $error("bus driven without strobe");
  a_read_drives: assert property ($fell(data_oe_n) |-> key_in[6:4] != 3'h0)
    else $error("bus driven for a non-read key");
  a_write_quiet: assert property (
    $rose(key_en_in) && key_in < 7'h10 |=> ##3 data_oe_n [*3])
    else $error("bus driven for an operand key");
  // Strobe held five cycles, so the read has landed
  a_status_msb: assert property (
    !data_oe_n && key_en_in && $past(key_en_in, 5) && key_in == dch_pkg::KEY_RD_STATUS
    |-> data_out[15])
    else $error("status top bit low");
  a_prio_kill: assert property (!$past(prio_in, 3) |-> !prio_out)
    else $error("chain passed without upstream grant");
  a_run_by_start: assert property ($rose(running) |-> key_in == dch_pkg::KEY_START)
    else $error("pass started without start key");
  // End of pass only follows a register write
  a_pass_held: assert property (
    running && !s_wvalid && !$past(s_wvalid) && !$past(s_wvalid, 2) |=> running)
    else $error("pass ended on its own");
  a_write_answer: assert property (s_wvalid && s_wready |-> ##[1:2] s_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid)
    else $error("read response missing");
  c_read_drive: cover property ($fell(data_oe_n));
  c_pass_start: cover property ($rose(running));
  c_pass_end: cover property ($fell(running));
endmodule
bind dch_cell dch_cell_checker dch_cell_checker_inst (.clk(clk), .rst_n(rst_n), .key_in(key_in),
  .key_en_in(key_en_in), .data_out(data_out), .data_oe_n(data_oe_n), .prio_in(prio_in),
  .prio_out(prio_out), .running(running), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid));
`default_nettype wire

// ===== dch_ctl_model.sv
`default_nettype none
module dch_ctl_model (
  input wire logic clk, // Clock
  input wire logic [15:0] cell_dout, // Cell drive value
  input wire logic cell_oe_n, // Cell drives when low
  output logic [6:0] key, // Key lines
  output logic key_en, // Key strobe
  output logic [15:0] bus // Resolved data bus
);
  timeunit 1ns;
  timeprecision 1ps;
  dch_pkg::dch_cmd_t cmd = '0;
  logic drv = 1'b0;
  logic [15:0] last_r = 16'h0;
  assign key = cmd.key;
  assign key_en = cmd.strobe;
  // shared bus level
  // Released bus flips its last level so a stale word never reads back
  assign bus = !cell_oe_n ? cell_dout : (drv ? cmd.data : ~last_r);
  always_ff @(posedge clk)
    last_r <= bus;
  task automatic access(input logic st, input logic [6:0] k, input logic [15:0] d,
    output logic [15:0] rd, output logic oe);
    @(posedge clk);
    cmd <= '{key: k, strobe: st, data: d};
    drv <= (k < 7'h10);
    repeat (6) @(posedge clk);
    rd = bus;
    oe = !cell_oe_n;
    cmd.strobe <= 1'b0;
    drv <= 1'b0;
    repeat (243) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic prio_in = 1'b1;
  logic key_en, oe_n, prio_out, running;
  logic [6:0] key;
  logic [15:0] bus, dout;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  // Flags, key, word; 4 plain, 5 expect word, 6 expect no drive, 0 strobe low
  logic [27:0] rows [49] = '{
    28'h6100000, 28'h0010000, 28'h6100000, 28'h4010000, 28'h5108001, 28'h511005a, 28'h40a1234,
    28'h5121234, 28'h5108011, 28'h4070000, 28'h408a1a1, 28'h408b2b2, 28'h5130002, 28'h4070000,
    28'h548a1a1, 28'h548b2b2, 28'h5130002, 28'h4090005, 28'h5160005, 28'h4040000, 28'h6100000,
    28'h402005b, 28'h6100000, 28'h402005a, 28'h5108011, 28'h4040000, 28'h4031234, 28'h5108011,
    28'h40b0000, 28'h4040000, 28'h4031234, 28'h6100000, 28'h4010000, 28'h40a0777, 28'h4040000,
    28'h4030777, 28'h5108011, 28'h4050000, 28'h6100000, 28'h4060000, 28'h5108011, 28'h4060000,
    28'h6100000, 28'h4040000, 28'h4010000, 28'h40c0000, 28'h5108019, 28'h4040000, 28'h5108019};
  initial forever #2 clk = ~clk;
  dch_cell dch_cell_inst (.clk(clk), .rst_n(rst_n), .key_in(key), .key_en_in(key_en),
    .data_in(bus), .data_out(dout), .data_oe_n(oe_n), .cell_addr_sw(8'h5a),
    .prio_in(prio_in), .prio_out(prio_out), .running(running), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  dch_ctl_model dch_ctl_model_inst (.clk(clk), .cell_dout(dout), .cell_oe_n(oe_n), .key(key),
    .key_en(key_en), .bus(bus));
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic run_key(input logic [27:0] r);
    logic [15:0] rd;
    logic oe;
    dch_ctl_model_inst.access(r[26], r[22:16], r[15:0], rd, oe);
    if (r[25:24] == 2'd1)
      chk_w($sformatf("key %h word", r[22:16]), {16'h0, r[15:0]}, {16'h0, rd});
    if (r[25:24] != 2'd0)
      chk_w($sformatf("key %h drive", r[22:16]), {31'h0, r[24]}, {31'h0, oe});
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 49; i++)
      run_key(rows[i]);
    $display("Test key table done");
    axi_rd(dch_pkg::REG_STATUS, d, r);
    chk_w("axi status", 32'h00008019, d);
    axi_wr(dch_pkg::REG_RESULT, 32'h42, r);
    axi_wr(dch_pkg::REG_SCOUNT, 32'h3, r);
    axi_wr(dch_pkg::REG_CTRL, 32'h1, r);
    chk_w("bresp", {30'h0, dch_pkg::RESP_OKAY}, {30'h0, r});
    chk_w("running", 32'h0, {31'h0, running});
    run_key(28'h5140042);
    run_key(28'h5150003);
    axi_rd(dch_pkg::REG_CTRL, d, r);
    chk_w("axi limit", 32'h5, d);
    axi_rd(8'h20, d, r);
    chk_w("rresp", {30'h0, dch_pkg::RESP_SLVERR}, {30'h0, r});
    axi_wr(8'h20, 32'h0, r);
    chk_w("bresp", {30'h0, dch_pkg::RESP_SLVERR}, {30'h0, r});
    $display("Test register bus done");
    run_key(28'h4050000);
    chk_w("prio_out", 32'h0, {31'h0, prio_out});
    @(posedge clk);
    prio_in <= 1'b0;
    run_key(28'h4060000);
    run_key(28'h6100000);
    @(posedge clk);
    prio_in <= 1'b1;
    run_key(28'h4060000);
    run_key(28'h5108011);
    chk_w("prio_out", 32'h1, {31'h0, prio_out});
    $display("Test priority chain done");
    run_key(28'h40c0000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk_w("reset outputs", 32'h2, {29'h0, running, oe_n, prio_out});
    rst_n <= 1'b1;
    run_key(28'h4010000);
    run_key(28'h5130000);
    run_key(28'h5108001);
    $display("Test reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
